// ---- bench/sadc_analog_model.sv ----
// Purpose: Analog side of the converter: selected input level against the trial code
// Assumes: Each channel holds a fixed level derived from its number
// Notes:   Unpowered comparator output toggles; an unknown would hide faults
`timescale 1ns/100ps
`default_nettype none
module sadc_analog_model
    import sadc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic [CHAN_W-1:0] mux_sel,
    input  wire logic [RES_W-1:0]  dac_code,
    input  wire logic              analog_pwr,
    output logic                   cmp_hi
);
    logic [RES_W-1:0] level;
    logic             junk_q = 1'h0;

    // Pins, temperature and supply each give a distinct level
    assign level = {mux_sel, 7'h2b};
    always @(posedge ref_clk) begin
        junk_q <= ~junk_q;
    end
    // Single-ended: level measured from ground only
    assign cmp_hi = analog_pwr ? (level >= dac_code) : junk_q;
endmodule : sadc_analog_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the converter sequencer
// Assumes: 125 MHz clock, inputs driven at the rising edge
// Notes:   Checks sampled at the falling edge to avoid races
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sadc_pkg::*;
    logic ref_clk = 1'h0, rstn = 1'h0, enable = 1'h1, burst_en = 1'h0;
    logic sw_start = 1'h0, tmr2_ovf = 1'h0, tmr3_ovf = 1'h0, ext_start = 1'h0;
    logic done_irq_en = 1'h0, done_clr = 1'h0, win_outside = 1'h0, win_clr = 1'h0;
    logic [1:0] trig_sel = 2'h0, acc_sel = 2'h0;
    logic [CHAN_W-1:0] chan_sel = 5'h00;
    logic [ACC_W-1:0] win_lo = 16'h0000, win_hi = 16'h0000, result;
    logic done_flag, done_irq, win_flag, win_irq, analog_pwr, busy, cmp_hi;
    logic [CHAN_W-1:0] mux_sel;
    logic [RES_W-1:0] dac_code;
    int err_count = 0, checks_done = 0, cyc = 0;

    always #4 ref_clk = ~ref_clk;

    sadc_seq dut (.ref_clk(ref_clk), .rstn(rstn), .enable(enable), .burst_en(burst_en),
        .trig_sel(trig_sel), .sw_start(sw_start), .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf),
        .ext_start(ext_start), .acc_sel(acc_sel), .chan_sel(chan_sel), .cmp_hi(cmp_hi),
        .done_irq_en(done_irq_en), .done_clr(done_clr), .win_outside(win_outside),
        .win_lo(win_lo), .win_hi(win_hi), .win_clr(win_clr), .result(result),
        .done_flag(done_flag), .done_irq(done_irq), .win_flag(win_flag), .win_irq(win_irq),
        .mux_sel(mux_sel), .dac_code(dac_code), .analog_pwr(analog_pwr), .busy(busy));
    sadc_analog_model model (.ref_clk(ref_clk), .mux_sel(mux_sel), .dac_code(dac_code),
        .analog_pwr(analog_pwr), .cmp_hi(cmp_hi));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [ACC_W-1:0] lvl(input logic [CHAN_W-1:0] c);
        return {4'h0, c, 7'h2b};
    endfunction : lvl

    task automatic fire(input logic [1:0] t);
        @(posedge ref_clk);
        trig_sel <= t;
        @(posedge ref_clk);
        sw_start  <= (t == TRIG_SW);
        tmr2_ovf  <= (t == TRIG_TMR2);
        tmr3_ovf  <= (t == TRIG_TMR3);
        ext_start <= (t == TRIG_EXT);
        @(posedge ref_clk);
        sw_start <= 1'h0;
        tmr2_ovf <= 1'h0;
        tmr3_ovf <= 1'h0;
        // Hold the pin a few cycles so the synchroniser surely sees it
        repeat (3) @(posedge ref_clk);
        ext_start <= 1'h0;
    endtask : fire

    task automatic conv(input logic [1:0] t, input logic [1:0] a, input logic [CHAN_W-1:0] c,
                        input int wake);
        int n;
        int k;
        logic [ACC_W-1:0] old;
        logic [ACC_W-1:0] sum;
        logic in_rng;
        n = (a == ACC_1) ? 1 : (a == ACC_4) ? 4 : (a == ACC_8) ? 8 : 16;
        sum = lvl(c) * n;
        @(posedge ref_clk);
        acc_sel  <= a;
        chan_sel <= c;
        @(negedge ref_clk);
        // Limits may have been set just before the call
        in_rng = (sum >= win_lo) && (sum <= win_hi);
        old = result;
        fire(t);
        k = 0;
        while (done_flag !== 1'h1 && k < n * 625 + wake + 60) begin
            @(negedge ref_clk);
            k++;
            if (k == 300) begin
                chk("mux_sel", mux_sel, c);
                chk("result_hold", result, old);
                chk("analog_pwr_on", analog_pwr, 1'h1);
                chk("busy", busy, 1'h1);
            end
        end
        chk("done_flag", done_flag, 1'h1);
        chk("samples_time", k >= n * 600, 1'h1);
        chk("result", result, sum);
        chk("dac_code", dac_code, lvl(c));
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk("done_irq", done_irq, done_irq_en);
        chk("win_flag", win_flag, win_outside ? !in_rng : in_rng);
        chk("win_irq", win_irq, win_outside ? !in_rng : in_rng);
        if (burst_en) begin
            repeat (4) @(negedge ref_clk);
            chk("analog_pwr_off", analog_pwr, 1'h0);
        end
        @(posedge ref_clk);
        done_clr <= 1'h1;
        win_clr  <= 1'h1;
        @(posedge ref_clk);
        done_clr <= 1'h0;
        win_clr  <= 1'h0;
        @(negedge ref_clk);
        chk("done_cleared", done_flag, 1'h0);
    endtask : conv

    always @(posedge ref_clk) begin
        cyc++;
        // Roughly 25000 cycles of work expected
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'h1;
        @(negedge ref_clk);
        chk("reset_result", result, 16'h0000);
        chk("reset_done", done_flag, 1'h0);
        for (int a = 0; a < 4; a++) begin
            @(posedge ref_clk);
            done_irq_en <= a[0];
            conv(TRIG_SW, a[1:0], 5'h03 + a[4:0], 0);
        end
        $display("test accumulate done");
        conv(TRIG_SW, ACC_1, CHAN_TEMP, 0);
        conv(TRIG_TMR2, ACC_1, CHAN_SUPPLY, 0);
        conv(TRIG_TMR3, ACC_1, 5'h1a, 0);
        conv(TRIG_EXT, ACC_1, 5'h00, 0);
        $display("test triggers done");
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            win_outside <= (i != 0);
            win_lo <= (i == 2) ? 16'h0000 : lvl(5'h05) - 16'h0001;
            win_hi <= (i == 2) ? 16'h0010 : lvl(5'h05) + 16'h0001;
            conv(TRIG_SW, ACC_1, 5'h05, 0);
        end
        $display("test window done");
        @(posedge ref_clk);
        burst_en <= 1'h1;
        conv(TRIG_TMR2, ACC_4, 5'h07, 25);
        $display("test burst done");
        @(posedge ref_clk);
        burst_en <= 1'h0;
        enable <= 1'h0;
        // Out of range channel must be ignored
        chan_sel <= 5'h1f;
        fire(TRIG_SW);
        repeat (700) @(negedge ref_clk);
        chk("off_busy", busy, 1'h0);
        chk("off_done", done_flag, 1'h0);
        chk("off_pwr", analog_pwr, 1'h0);
        chk("mux_refused", mux_sel, 5'h07);
        $display("test shutdown done");
        summarize();
    end
endmodule : tb
`default_nettype wire

// ---- src/sadc_core.sv ----
// Purpose: Successive-approximation step engine for one sample
// Assumes: Comparator input is settled and synchronous to ref_clk
// Notes:   Twelve bit trials, then done pulse
`timescale 1ns/100ps
`default_nettype none
module sadc_core
    import sadc_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  rstn,
    input  wire logic  cmp_hi,
    output logic [RES_W-1:0] dac_code,
    sadc_core_if.core  cif
);
    logic [RES_W-1:0] res_q;
    logic [RES_W-1:0] bit_q;
    logic             busy_q;
    logic             done_q;
    logic [1:0]       wait_q;

    // One trial per settle window, MSB first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            res_q  <= '0;
            bit_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            wait_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (cif.start && !busy_q) begin
                res_q  <= {1'b1, {(RES_W-1){1'b0}}};
                bit_q  <= {1'b1, {(RES_W-1){1'b0}}};
                wait_q <= '0;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q + 2'h1;
                // Comparator answer lags the code; judging early reads a stale trial
                if (wait_q == 2'(CMP_LAT - 1)) begin
                    wait_q <= '0;
                    if (!cmp_hi)
                        res_q <= (res_q & ~bit_q) | (bit_q >> 1);
                    else
                        res_q <= res_q | (bit_q >> 1);
                    bit_q <= bit_q >> 1;
                    if (bit_q[0]) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        if (!cmp_hi)
                            res_q <= res_q & ~bit_q;
                    end
                end
            end
        end
    end

    assign dac_code   = res_q;
    assign cif.busy   = busy_q;
    assign cif.done   = done_q;
    assign cif.sample = res_q;
endmodule : sadc_core
`default_nettype wire

// ---- src/sadc_core_if.sv ----
// Purpose: Carrier between sequencer and converter core
// Assumes: Single clock domain
// Notes:   Start is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface sadc_core_if;
    import sadc_pkg::*;
    logic             start;
    logic             busy;
    logic             done;
    logic [RES_W-1:0] sample;
    modport seq  (output start, input busy, input done, input sample);
    modport core (input start, output busy, output done, output sample);
endinterface : sadc_core_if
`default_nettype wire

// ---- src/sadc_pkg.sv ----
// Purpose: Shared constants and types for the converter sequencer
// Assumes: 125 MHz reference clock
// Notes:   Channel map: 0..23 port pins, 24 temp, 25 supply, 26 spare pin
package sadc_pkg;
    localparam int unsigned RES_W        = 12;
    localparam int unsigned CHAN_NUM     = 27;
    localparam int unsigned CHAN_W       = 5;
    localparam int unsigned ACC_W        = 16;
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned MAX_KSPS     = 200;
    localparam int unsigned CONV_CYC     = (CLK_MHZ * 1000) / MAX_KSPS;
    localparam int unsigned WAKE_NS      = 200;
    localparam int unsigned WAKE_CYC     = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W        = 10;
    // Trial settle: code flop, two comparator sync flops, then sample
    localparam int unsigned CMP_LAT      = 4;
    localparam logic [CHAN_W-1:0] CHAN_TEMP   = 5'h18;
    localparam logic [CHAN_W-1:0] CHAN_SUPPLY = 5'h19;
    localparam logic [1:0] TRIG_SW   = 2'h0;
    localparam logic [1:0] TRIG_TMR2 = 2'h1;
    localparam logic [1:0] TRIG_TMR3 = 2'h2;
    localparam logic [1:0] TRIG_EXT  = 2'h3;
    localparam logic [1:0] ACC_1     = 2'h0;
    localparam logic [1:0] ACC_4     = 2'h1;
    localparam logic [1:0] ACC_8     = 2'h2;
    localparam logic [1:0] ACC_16    = 2'h3;
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_IDLE  = 5'h02,
        ST_WAKE  = 5'h04,
        ST_CONV  = 5'h08,
        ST_DONE  = 5'h10
    } sadc_state_type;
endpackage : sadc_pkg

// ---- src/sadc_seq.sv ----
// Purpose: Converter sequencer: triggers, accumulation, window, burst
// Assumes: Timer overflows are ref_clk pulses; ext start and comparator are pins
// Notes:   Channel select is driven to the analog multiplexer
`timescale 1ns/100ps
`default_nettype none
module sadc_seq
    import sadc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              enable,
    input  wire logic              burst_en,
    input  wire logic [1:0]        trig_sel,
    input  wire logic              sw_start,
    input  wire logic              tmr2_ovf,
    input  wire logic              tmr3_ovf,
    input  wire logic              ext_start,
    input  wire logic [1:0]        acc_sel,
    input  wire logic [CHAN_W-1:0] chan_sel,
    input  wire logic              cmp_hi,
    input  wire logic              done_irq_en,
    input  wire logic              done_clr,
    input  wire logic              win_outside,
    input  wire logic [ACC_W-1:0]  win_lo,
    input  wire logic [ACC_W-1:0]  win_hi,
    input  wire logic              win_clr,
    output logic [ACC_W-1:0]       result,
    output logic                   done_flag,
    output logic                   done_irq,
    output logic                   win_flag,
    output logic                   win_irq,
    output logic [CHAN_W-1:0]      mux_sel,
    output logic [RES_W-1:0]       dac_code,
    output logic                   analog_pwr,
    output logic                   busy
);
    sadc_core_if cif ();

    sadc_state_type   state_q;
    logic [1:0]       ext_sync_q;
    logic             ext_prev_q;
    logic [1:0]       cmp_sync_q;
    logic [ACC_W-1:0] acc_q;
    logic [4:0]       left_q;
    logic [CNT_W-1:0] slot_q;
    logic [ACC_W-1:0] result_q;
    logic             done_q;
    logic             win_q;
    logic [CHAN_W-1:0] mux_q;
    logic             pwr_q;
    logic             start_q;
    logic             trig;
    logic             ext_rise;
    logic [ACC_W-1:0] acc_sum;
    logic             in_win;
    logic [RES_W-1:0] core_dac;

    function automatic logic [4:0] acc_count(input logic [1:0] sel);
        case (sel)
            ACC_4:   acc_count = 5'h04;
            ACC_8:   acc_count = 5'h08;
            ACC_16:  acc_count = 5'h10;
            default: acc_count = 5'h01;
        endcase
    endfunction : acc_count

    // Pin inputs go through two flops first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync_q <= 2'h0;
            ext_prev_q <= 1'b0;
            cmp_sync_q <= 2'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_start};
            ext_prev_q <= ext_sync_q[1];
            cmp_sync_q <= {cmp_sync_q[0], cmp_hi};
        end
    end
    assign ext_rise = ext_sync_q[1] && !ext_prev_q;

    always_comb begin
        case (trig_sel)
            TRIG_SW:   trig = sw_start;
            TRIG_TMR2: trig = tmr2_ovf;
            TRIG_TMR3: trig = tmr3_ovf;
            TRIG_EXT:  trig = ext_rise;
            default:   trig = 1'b0;
        endcase
    end

    // Sixteen 12-bit samples need 16 bits
    assign acc_sum = acc_q + {{(ACC_W-RES_W){1'b0}}, cif.sample};

    // Sequencer; state ST_OFF is shutdown, left only when enabled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_OFF;
            acc_q   <= '0;
            left_q  <= 5'h00;
            slot_q  <= '0;
            start_q <= 1'b0;
            pwr_q   <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (state_q)
                ST_OFF: begin
                    pwr_q <= 1'b0;
                    if (enable && !burst_en)
                        state_q <= ST_IDLE;
                    else if (enable && burst_en && trig) begin
                        pwr_q   <= 1'b1;
                        slot_q  <= '0;
                        acc_q   <= '0;
                        left_q  <= acc_count(acc_sel);
                        state_q <= ST_WAKE;
                    end
                end
                ST_IDLE: begin
                    pwr_q <= 1'b1;
                    if (!enable || burst_en)
                        state_q <= ST_OFF;
                    else if (trig) begin
                        acc_q   <= '0;
                        left_q  <= acc_count(acc_sel);
                        slot_q  <= '0;
                        start_q <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_WAKE: begin
                    slot_q <= slot_q + 1'b1;
                    if (slot_q == CNT_W'(WAKE_CYC - 1)) begin
                        slot_q  <= '0;
                        start_q <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Fixed slot keeps the sample rate at or below the limit
                    if (slot_q != CNT_W'(CONV_CYC - 1))
                        slot_q <= slot_q + 1'b1;
                    if (cif.done) begin
                        acc_q  <= acc_sum;
                        left_q <= left_q - 5'h01;
                    end
                    if (!cif.busy && !start_q && !cif.done
                        && slot_q == CNT_W'(CONV_CYC - 1)) begin
                        slot_q <= '0;
                        if (left_q == 5'h00)
                            state_q <= ST_DONE;
                        else
                            start_q <= 1'b1;
                    end
                end
                ST_DONE: begin
                    if (burst_en) begin
                        pwr_q   <= 1'b0;
                        state_q <= ST_OFF;
                    end else
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_OFF;
            endcase
            // Shutdown overrides every state, waking and done included
            if (!enable) begin
                state_q <= ST_OFF;
                start_q <= 1'b0;
            end
        end
    end

    // Result word frozen between completions
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            result_q <= '0;
        else if (state_q == ST_DONE)
            result_q <= acc_q;
    end

    assign in_win = (acc_q >= win_lo) && (acc_q <= win_hi);

    // Set wins over clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            win_q  <= 1'b0;
        end else begin
            if (state_q == ST_DONE)
                done_q <= 1'b1;
            else if (done_clr)
                done_q <= 1'b0;
            if (state_q == ST_DONE && (in_win ^ win_outside))
                win_q <= 1'b1;
            else if (win_clr)
                win_q <= 1'b0;
        end
    end

    // Channel held steady for a whole conversion
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            mux_q <= '0;
        else if (state_q != ST_CONV && state_q != ST_WAKE
                 && chan_sel < CHAN_W'(CHAN_NUM))
            mux_q <= chan_sel;
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_irq   <= 1'b0;
            win_irq    <= 1'b0;
            analog_pwr <= 1'b0;
            busy       <= 1'b0;
            dac_code   <= '0;
        end else begin
            done_irq   <= done_q && done_irq_en;
            win_irq    <= win_q;
            analog_pwr <= pwr_q;
            busy       <= (state_q == ST_CONV) || (state_q == ST_WAKE);
            dac_code   <= core_dac;
        end
    end

    sadc_core u_core (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .cmp_hi   (cmp_sync_q[1]),
        .dac_code (core_dac),
        .cif      (cif.core)
    );
    assign cif.start = start_q;

    assign result    = result_q;
    assign done_flag = done_q;
    assign win_flag  = win_q;
    assign mux_sel   = mux_q;

    // Assertions
    property p_res_hold;
        @(posedge ref_clk) disable iff (!rstn)
        state_q != ST_DONE |=> $stable(result_q);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result moved");

    property p_done_set;
        @(posedge ref_clk) disable iff (!rstn)
        state_q == ST_DONE |=> done_q;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");

    property p_irq;
        @(posedge ref_clk) disable iff (!rstn)
        done_q && done_irq_en |=> done_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    sequence s_win_follow;
        win_q ##1 win_irq;
    endsequence

    property p_win;
        @(posedge ref_clk) disable iff (!rstn)
        state_q == ST_DONE && (in_win ^ win_outside) |=> s_win_follow;
    endproperty
    a_win: assert property (p_win) else $error("window missed");

    property p_off;
        @(posedge ref_clk) disable iff (!rstn)
        !enable |=> state_q == ST_OFF;
    endproperty
    a_off: assert property (p_off) else $error("not shut down");

    property p_clear;
        @(posedge ref_clk) disable iff (!rstn)
        state_q == ST_IDLE && trig && enable && !burst_en |=> acc_q == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("acc not cleared");

    property p_ext;
        @(posedge ref_clk) disable iff (!rstn)
        ext_rise && trig_sel == TRIG_EXT && state_q == ST_IDLE && enable && !burst_en
            |=> start_q;
    endproperty
    a_ext: assert property (p_ext) else $error("ext start lost");

    property p_burst_sleep;
        @(posedge ref_clk) disable iff (!rstn)
        state_q == ST_DONE && burst_en |=> !pwr_q && state_q == ST_OFF;
    endproperty
    a_burst_sleep: assert property (p_burst_sleep) else $error("burst no sleep");
endmodule : sadc_seq
`default_nettype wire
